// >>> src/capture_bus_if.sv
// Carrier between the event logic and the capture store
`timescale 1ns/1ps
interface capture_bus_if #(
    parameter int NCH = 4,
    parameter int W   = 16
);
    logic [NCH-1:0]         we;
    logic [W-1:0]           wdata;
    logic [$clog2(NCH)-1:0] raddr;
    logic [W-1:0]           rdata;
    modport store (input we, input wdata, input raddr, output rdata);
    modport user  (output we, output wdata, output raddr, input rdata);
endinterface

// >>> src/capture_store.sv
// Per-channel capture value store with registered read port
`timescale 1ns/1ps
module capture_store
    import timer_event_pkg::*;
#(
    parameter int NCH = 4,
    parameter int W   = 16
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    capture_bus_if.store     bus
);
    logic [W-1:0] mem [NCH];

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_entry
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    mem[g] <= '0;
                end else if (bus.we[g]) begin
                    mem[g] <= bus.wdata;
                end
            end
        end
    endgenerate

    // Registered read keeps the bus mux off the storage path
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bus.rdata <= '0;
        end else begin
            bus.rdata <= mem[bus.raddr];
        end
    end
endmodule

// >>> src/timer_event_gen.sv
// Timer counter with software event generation and status flags
// Function
// - Repeat flags for channels 1-4 at bits 9-12
// - Bit 0 write reinitialises counter, raises update
// - Update request clears itself after being taken
// - Update clears prescaler count, keeps division factor
// - Down counting update loads auto reload value
// - Up or center counting update clears counter
// - Bit 1 forces channel 1 event; zero ignored
// - Channel requests self-clear in hardware
// - Output channel: set flag, irq, dma if enabled
// - Input channel: capture counter, flag, irq, dma
// - Capture while flag set sets repeat flag
// - Bits 2-4 force channels 2-4 events
// - Bit 6 forces trigger, self-clears
// - Every enabled update event sets flag bit 0
// - Trigger sets flag bit 6, software clears
// - Repeat flags only in input capture, software clears
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module timer_event_gen
    import timer_event_pkg::*;
#(
    parameter int NCH = NUM_CHAN,
    parameter int W   = CNT_W
) (
    input  wire logic           clk_i,
    input  wire logic           sys_rst_i,
    input  wire logic           psel_i,
    input  wire logic           penable_i,
    input  wire logic           pwrite_i,
    input  wire logic [7:0]     paddr_i,
    input  wire logic [31:0]    pwdata_i,
    output logic      [31:0]    prdata_o,
    output logic                pready_o,
    output logic                pslverr_o,
    output logic      [W-1:0]   counter_o,
    output logic                update_event_o,
    output logic                trigger_event_o,
    output logic      [NCH-1:0] chan_irq_o,
    output logic      [NCH-1:0] chan_dma_o
);
    logic [15:0]    ctrl;
    logic [15:0]    evt_en;
    logic [15:0]    flags;
    logic [15:0]    evt_req;
    logic [NCH-1:0] chan_input;
    logic [15:0]    prescale;
    logic [15:0]    auto_reload_value;
    logic [15:0]    psc_cnt;
    logic [W-1:0]   cnt;
    logic           center_down;
    logic           wr_en;
    logic           rd_en;
    logic           hit;
    logic [31:0]    next_rdata;
    logic           tick;
    logic           count_down;
    logic           center;
    logic           overflow;
    logic           update_request_bit;
    logic           trigger_request_bit;
    logic           update_evt;
    logic [NCH-1:0] chan_evt;
    logic [NCH-1:0] cap_read;
    logic [15:0]    flag_set;
    logic [15:0]    flag_clr;

    capture_bus_if #(.NCH(NCH), .W(W)) cap_bus ();

    capture_store #(.NCH(NCH), .W(W)) u_store (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .bus       (cap_bus.store)
    );

    // APB: one wait cycle so the registered capture read is ready
    assign wr_en = psel_i & penable_i & pready_o & pwrite_i;
    assign rd_en = psel_i & penable_i & pready_o & ~pwrite_i;
    assign cap_bus.raddr = paddr_i[$clog2(NCH)+1:2];

    always_comb begin
        next_rdata = 32'h0000_0000;
        hit        = 1'b1;
        if (paddr_i >= CAPTURE_OFS && paddr_i <= CAPTURE_END_OFS
            && paddr_i[1:0] == 2'h0) begin
            next_rdata[W-1:0] = cap_bus.rdata;
        end else begin
            unique case (paddr_i)
                CTRL_OFS:      next_rdata[15:0] = ctrl;
                EVT_EN_OFS:    next_rdata[15:0] = evt_en;
                FLAGS_OFS:     next_rdata[15:0] = flags;
                EVT_REQ_OFS:   next_rdata = 32'h0000_0000;
                CHAN_MODE_OFS: next_rdata[NCH-1:0] = chan_input;
                COUNTER_OFS:   next_rdata[W-1:0] = cnt;
                PRESCALE_OFS:  next_rdata[15:0] = prescale;
                RELOAD_OFS:    next_rdata[15:0] = auto_reload_value;
                default:       hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl              <= CTRL_RST;
            evt_en            <= EVT_EN_RST;
            chan_input        <= CHAN_MODE_RST;
            prescale          <= PRESCALE_RST;
            auto_reload_value <= RELOAD_RST;
        end else if (wr_en) begin
            unique case (paddr_i)
                CTRL_OFS:      ctrl <= pwdata_i[15:0] & CTRL_MASK;
                EVT_EN_OFS:    evt_en <= pwdata_i[15:0] & EVT_EN_MASK;
                CHAN_MODE_OFS: chan_input <= pwdata_i[NCH-1:0];
                PRESCALE_OFS:  prescale <= pwdata_i[15:0];
                RELOAD_OFS:    auto_reload_value <= pwdata_i[15:0];
                default:       ;
            endcase
        end
    end

    // Request bits live one cycle, then drop with no software action
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            evt_req <= EVT_REQ_RST;
        end else if (wr_en && paddr_i == EVT_REQ_OFS) begin
            evt_req <= pwdata_i[15:0] & EVT_REQ_MASK;
        end else begin
            evt_req <= EVT_REQ_RST;
        end
    end

    assign update_request_bit  = evt_req[UPDATE_BIT];
    assign trigger_request_bit = evt_req[TRIGGER_BIT];
    assign chan_evt = evt_req[CHAN_LSB +: NCH];

    assign center     = |ctrl[CTRL_CMS_LSB +: 2];
    assign count_down = ~center & ctrl[CTRL_DOWN_BIT];
    assign tick       = ctrl[CTRL_EN_BIT] & (psc_cnt == prescale);
    assign overflow   = tick & (center
        ? (center_down ? cnt == '0 : cnt == auto_reload_value[W-1:0])
        : (count_down  ? cnt == '0 : cnt == auto_reload_value[W-1:0]));
    // Update disable suppresses both natural and forced update events
    assign update_evt = (overflow | update_request_bit)
                        & ~ctrl[CTRL_UDIS_BIT];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            psc_cnt <= 16'h0000;
        end else if (update_request_bit || tick) begin
            psc_cnt <= 16'h0000;
        end else if (ctrl[CTRL_EN_BIT]) begin
            psc_cnt <= psc_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt         <= '0;
            center_down <= 1'b0;
        end else if (update_request_bit) begin
            center_down <= 1'b0;
            if (count_down) begin
                cnt <= auto_reload_value[W-1:0];
            end else begin
                cnt <= '0;
            end
        end else if (tick) begin
            if (center) begin
                if (overflow) begin
                    center_down <= ~center_down;
                    cnt <= center_down ? cnt + W'(1) : cnt - W'(1);
                end else begin
                    cnt <= center_down ? cnt - W'(1) : cnt + W'(1);
                end
            end else if (count_down) begin
                cnt <= overflow ? auto_reload_value[W-1:0] : cnt - W'(1);
            end else begin
                cnt <= overflow ? '0 : cnt + W'(1);
            end
        end
    end

    // Capture takes the count as it stands when the request is taken
    assign cap_bus.we    = chan_evt & chan_input;
    assign cap_bus.wdata = cnt;

    always_comb begin
        flag_set              = 16'h0000;
        flag_set[UPDATE_BIT]  = update_evt;
        flag_set[TRIGGER_BIT] = trigger_request_bit;
        flag_set[CHAN_LSB +: NCH] = chan_evt;
        // Repeat only when input mode and flag already high
        flag_set[REPEAT_LSB +: NCH] = chan_evt & chan_input
            & flags[CHAN_LSB +: NCH];
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_capread
            assign cap_read[g] = rd_en
                && paddr_i == CAPTURE_OFS + 8'(4 * g);
        end
    endgenerate

    always_comb begin
        flag_clr = 16'h0000;
        if (wr_en && paddr_i == FLAGS_OFS) begin
            flag_clr = ~pwdata_i[15:0] & FLAGS_MASK;
        end
        flag_clr[CHAN_LSB +: NCH] = flag_clr[CHAN_LSB +: NCH] | cap_read;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            flags <= FLAGS_RST;
        end else begin
            flags <= (flags & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            chan_irq_o      <= '0;
            chan_dma_o      <= '0;
            update_event_o  <= 1'b0;
            trigger_event_o <= 1'b0;
        end else begin
            chan_irq_o      <= chan_evt & evt_en[CHAN_LSB +: NCH];
            chan_dma_o      <= chan_evt & evt_en[DMA_EN_LSB +: NCH];
            update_event_o  <= update_evt;
            trigger_event_o <= trigger_request_bit;
        end
    end

    assign counter_o = cnt;
endmodule

// >>> src/timer_event_pkg.sv
// Register map, field positions and reset values of the timer event block
package timer_event_pkg;
    localparam int          NUM_CHAN        = 4;
    localparam int          CNT_W           = 16;
    localparam logic [7:0]  CTRL_OFS        = 8'h00;
    localparam logic [7:0]  EVT_EN_OFS      = 8'h0C;
    localparam logic [7:0]  FLAGS_OFS       = 8'h10;
    localparam logic [7:0]  EVT_REQ_OFS     = 8'h14;
    localparam logic [7:0]  CHAN_MODE_OFS   = 8'h18;
    localparam logic [7:0]  COUNTER_OFS     = 8'h24;
    localparam logic [7:0]  PRESCALE_OFS    = 8'h28;
    localparam logic [7:0]  RELOAD_OFS      = 8'h2C;
    localparam logic [7:0]  CAPTURE_OFS     = 8'h30;
    localparam logic [7:0]  CAPTURE_END_OFS = 8'h3C;
    localparam int          CTRL_EN_BIT     = 0;
    localparam int          CTRL_UDIS_BIT   = 1;
    localparam int          CTRL_DOWN_BIT   = 4;
    localparam int          CTRL_CMS_LSB    = 5;
    localparam int          UPDATE_BIT      = 0;
    localparam int          CHAN_LSB        = 1;
    localparam int          TRIGGER_BIT     = 6;
    localparam int          REPEAT_LSB      = 9;
    localparam int          DMA_EN_LSB      = 9;
    localparam logic [15:0] EVT_REQ_MASK    = 16'h005F;
    localparam logic [15:0] FLAGS_MASK      = 16'h1E5F;
    localparam logic [15:0] EVT_EN_MASK     = 16'h1E1E;
    localparam logic [15:0] CTRL_MASK       = 16'h0073;
    localparam logic [15:0] CTRL_RST        = 16'h0000;
    localparam logic [15:0] EVT_EN_RST      = 16'h0000;
    localparam logic [15:0] FLAGS_RST       = 16'h0000;
    localparam logic [15:0] EVT_REQ_RST     = 16'h0000;
    localparam logic [3:0]  CHAN_MODE_RST   = 4'h0;
    localparam logic [15:0] PRESCALE_RST    = 16'h0000;
    localparam logic [15:0] RELOAD_RST      = 16'hFFFF;
endpackage

// >>> test/tb_timer_event_gen.sv
// Self-checking bench for the timer event block
`timescale 1ns/1ps
module tb_timer_event_gen
    import timer_event_pkg::*;
();
    logic        clk_i     = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [7:0]  paddr_i   = 8'h00;
    logic [31:0] pwdata_i  = 32'h0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [15:0] counter_o;
    logic        update_event_o;
    logic        trigger_event_o;
    logic [3:0]  chan_irq_o;
    logic [3:0]  chan_dma_o;
    logic [31:0] rd;
    logic        err;
    int          n_mismatch      = 0;
    int          samples_checked = 0;
    int          n_upd           = 0;
    int          n_trig          = 0;
    int          n_irq[4]        = '{0, 0, 0, 0};
    int          n_dma[4]        = '{0, 0, 0, 0};
    timer_event_gen u_timer_event_gen (.*);
    always #50 clk_i = ~clk_i;
    // Pulse tallies, so short pulses are never missed between accesses
    always @(posedge clk_i) begin
        n_upd  <= n_upd + int'(update_event_o);
        n_trig <= n_trig + int'(trigger_event_o);
        for (int k = 0; k < 4; k++) begin
            n_irq[k] <= n_irq[k] + int'(chan_irq_o[k]);
            n_dma[k] <= n_dma[k] + int'(chan_dma_o[k]);
        end
    end
    task automatic check(input string s, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            t++;
        end while (pready_o !== 1'b1 && t < 20);
        rd  = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (pready_o !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] pready expected 1 seen %b", pready_o);
            conclude();
        end
    endtask
    task automatic rc(input string s, input logic [7:0] a, input int e);
        apb(1'b0, a, 32'h0);
        check(s, e, rd);
    endtask
    task automatic sc_update();
        apb(1'b1, PRESCALE_OFS, 32'h3);
        apb(1'b1, CTRL_OFS, 32'h1);
        repeat (30) @(posedge clk_i);
        apb(1'b1, CTRL_OFS, 32'h0);
        apb(1'b1, EVT_REQ_OFS, 32'h1);
        rc("counter", COUNTER_OFS, 0);
        rc("request", EVT_REQ_OFS, 0);
        rc("prescale", PRESCALE_OFS, 3);
        rc("flags", FLAGS_OFS, 1);
        check("updates", 1, n_upd);
        apb(1'b1, RELOAD_OFS, 32'h1234);
        apb(1'b1, CTRL_OFS, 32'h10);
        // Reserved bits set beside the update request must do nothing
        apb(1'b1, EVT_REQ_OFS, 32'hFFA1);
        rc("counter", COUNTER_OFS, 'h1234);
        rc("flags", FLAGS_OFS, 1);
        // Center wins over down; update disable hides flag and pulse only
        apb(1'b1, CTRL_OFS, 32'h0000_0032);
        apb(1'b1, FLAGS_OFS, 32'h0000_0000);
        apb(1'b1, EVT_REQ_OFS, 32'h0000_0001);
        rc("counter", COUNTER_OFS, 32'h0000_0000);
        rc("flags", FLAGS_OFS, 32'h0000_0000);
        check("updates", 2, n_upd);
        apb(1'b1, CTRL_OFS, 32'h0000_0010);
        apb(1'b1, EVT_REQ_OFS, 32'h0000_0001);
        rc("counter", COUNTER_OFS, 32'h0000_1234);
    endtask
    task automatic sc_chan();
        apb(1'b1, FLAGS_OFS, 32'h0);
        apb(1'b1, CHAN_MODE_OFS, 32'hE);
        apb(1'b1, EVT_EN_OFS, 32'h0E1E);
        apb(1'b1, EVT_REQ_OFS, 32'h0);
        rc("flags", FLAGS_OFS, 0);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, EVT_REQ_OFS, 32'h2 << k);
            rc("flags", FLAGS_OFS, (4 << k) - 2);
        end
        apb(1'b1, EVT_REQ_OFS, 32'h1E);
        rc("flags", FLAGS_OFS, 'h1C1E);
        apb(1'b1, FLAGS_OFS, 32'hF7FF);
        rc("flags", FLAGS_OFS, 'h141E);
        rc("capture", CAPTURE_OFS + 8'h4, 'h1234);
        // Reading the capture value drops that channel's flag
        rc("flags", FLAGS_OFS, 32'h0000_141A);
        for (int k = 0; k < 4; k++) begin
            check("irq", 2, n_irq[k]);
            check("dma", (k == 3) ? 0 : 2, n_dma[k]);
        end
    endtask
    task automatic sc_trig();
        apb(1'b1, EVT_REQ_OFS, 32'h40);
        rc("flags", FLAGS_OFS, 32'h0000_145A);
        rc("request", EVT_REQ_OFS, 0);
        check("triggers", 1, n_trig);
        apb(1'b1, FLAGS_OFS, 32'hFFBF);
        rc("flags", FLAGS_OFS, 32'h0000_141A);
        apb(1'b0, 8'h42, 32'h0);
        check("slverr", 1, {31'h0, err});
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        sc_update();
        sc_chan();
        sc_trig();
        conclude();
    end
endmodule

// >>> test/timer_event_gen_asserts.sv
// Port level checks of the timer event block
`timescale 1ns/1ps
module timer_event_gen_asserts
    import timer_event_pkg::*;
#(
    parameter int NCH = NUM_CHAN,
    parameter int W   = CNT_W
) (
    input wire logic           clk_i,
    input wire logic           sys_rst_i,
    input wire logic           psel_i,
    input wire logic           penable_i,
    input wire logic           pwrite_i,
    input wire logic [7:0]     paddr_i,
    input wire logic [31:0]    pwdata_i,
    input wire logic [31:0]    prdata_o,
    input wire logic           pready_o,
    input wire logic           pslverr_o,
    input wire logic [W-1:0]   counter_o,
    input wire logic           update_event_o,
    input wire logic           trigger_event_o,
    input wire logic [NCH-1:0] chan_irq_o,
    input wire logic [NCH-1:0] chan_dma_o
);
    logic        done;
    logic        wr_req;
    logic        down;
    logic [15:0] ctrl_q;
    logic [15:0] reload_q;
    assign done   = psel_i && penable_i && pready_o;
    assign wr_req = done && pwrite_i && paddr_i == EVT_REQ_OFS;
    assign down   = ctrl_q[CTRL_DOWN_BIT] && ctrl_q[CTRL_CMS_LSB+:2] == 2'h0;
    // Shadows so the expected reload value follows the programmed mode
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_q   <= CTRL_RST;
            reload_q <= RELOAD_RST;
        end else if (done && pwrite_i) begin
            if (paddr_i == CTRL_OFS) ctrl_q <= pwdata_i[15:0];
            if (paddr_i == RELOAD_OFS) reload_q <= pwdata_i[15:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    req_reads_zero_a: assert property (
        done && !pwrite_i && paddr_i == EVT_REQ_OFS |-> prdata_o == '0)
        else $error("Request register reads nonzero");
    trig_pulse_a: assert property (
        wr_req && pwdata_i[TRIGGER_BIT] |-> ##2 trigger_event_o ##1
        !trigger_event_o) else $error("Trigger pulse wrong");
    trig_cause_a: assert property (
        trigger_event_o |-> $past(wr_req, 2) && $past(pwdata_i[6], 2))
        else $error("Trigger pulse without request");
    irq_cause_a: assert property (
        chan_irq_o != '0 |-> $past(wr_req, 2) &&
        (chan_irq_o & ~$past(pwdata_i[4:1], 2)) == '0)
        else $error("Channel irq without request");
    dma_cause_a: assert property (
        chan_dma_o != '0 |-> $past(wr_req, 2) &&
        (chan_dma_o & ~$past(pwdata_i[4:1], 2)) == '0)
        else $error("Channel dma without request");
    upd_pulse_a: assert property (
        wr_req && pwdata_i[UPDATE_BIT] && !ctrl_q[CTRL_UDIS_BIT]
        |-> ##2 update_event_o) else $error("Update pulse missing");
    upd_clear_a: assert property (
        wr_req && pwdata_i[UPDATE_BIT] && !down |-> ##2 counter_o == '0)
        else $error("Counter not cleared");
    upd_load_a: assert property (
        wr_req && pwdata_i[UPDATE_BIT] && down
        |-> ##2 counter_o == reload_q[W-1:0]) else $error("Reload missed");
endmodule
bind timer_event_gen timer_event_gen_asserts #(.NCH(NCH), .W(W)) u_chk (.*);
